// File: hdl/sfc_defines.vh
// Purpose: shared constants for the serial flash command slice
// Assumes: included by bare name
// Notes:   opcodes, status layout, id stream geometry
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
`define SFC_OP_WREN       8'h06
`define SFC_OP_WRDI       8'h04
`define SFC_OP_RDID       8'h9f
`define SFC_OP_RDID_ALT   8'h9e
`define SFC_OP_RDSR       8'h05
`define SFC_OP_WRSR       8'h01
`define SFC_OP_PP         8'h02
`define SFC_OP_SE         8'hd8
`define SFC_OP_BE         8'hc7
`define SFC_ST_BUSY       0
`define SFC_ST_LATCH      1
`define SFC_ST_PROT0      2
`define SFC_ST_PROT1      3
`define SFC_ST_LOCK       7
`define SFC_IDLEN         8'h10
`define SFC_ID_BYTES      5'd20
`define SFC_ID_LAST       5'd19
`define SFC_CUST_FIRST    5'd4
`define SFC_BIT_LAST      3'h7
`define SFC_ERR_NONE      2'h0
`define SFC_CYC_NS        10
`define SFC_CYCLE_NS      1000
`endif

// File: hdl/sfc_fifo.v
// Purpose: small flip-flop fifo for outgoing id/status bytes
// Assumes: single clock, same-cycle push and pop allowed
// Notes:   full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             flush,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ff;
   reg [AW-1:0]    rd_ff;
   reg [AW:0]      cnt_ff;
   wire            push = in_valid && in_ready;
   wire            pop  = out_valid && out_ready;
   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rd_ff];
   // pointers and count; flush empties at deselect
   always @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
         if (pop)  rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
   // storage, no reset needed
   always @(posedge clk) begin
      if (push) mem_ff[wr_ff] <= in_data;
   end
endmodule // sfc_fifo
`default_nettype wire

// File: hdl/sfc_top.v
// Purpose: command interpreter for status, identification and write-enable latch
// Assumes: spi mode 0/3, link pins sampled by clk (3 flops, 2nd==3rd agree)
// Notes:   program/erase engines are outside; this block owns the
//          latch, status byte, protect bits and id stream
//          the link clock is oversampled, so clk must run well above
//          eight times the link rate; a faster host loses bits
//          region checks for program/erase stay with the array engine
// Overview of operation
// - select, shift write-disable opcode, deselect; latch then clears.
// - latch clears at reset and completion of erase, program, status write, disable.
// - id stream starts with one maker byte.
// - then memory type byte and capacity byte.
// - then length byte 10h and sixteen custom factory bytes.
// - id request ignored while erase or program runs; cycle unaffected.
// - after select the host shifts an 8-bit opcode.
// - id bits change on falling clock edges: 24-bit id, length, 16 bytes.
// - deselect ends output anytime; device returns to standby.
// - status reads served at all times, even during busy cycles.
// - status byte repeats while selected.
// - busy bit is 1 during status write, program or erase.
// - enable bit mirrors latch; at 0 write/program/erase refused.
// - protect bits nonvolatile, changed only by status write; here reset reloads them from BP_INIT.
// - protect bits nonzero refuse program/erase to protected region.
// - protect bits writable only outside hardware-locked mode.
// - whole-array erase only when all protect bits are zero.
// - locked mode when lock bit is 1 and protect pin low.
// - in locked mode lock and protect bits read-only, status write refused.
// - everything moves msb first.
// - write-disable counts only if deselect falls on an 8-clock boundary.
// - status bits 6..4 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"
module sfc_top #(
   parameter [7:0]   MAKER_ID  = 8'h5a,   // arbitrary value
   parameter [7:0]   MEM_TYPE  = 8'h3c,   // arbitrary value
   parameter [7:0]   MEM_CAP   = 8'h11,   // arbitrary value
   parameter [127:0] CUSTOM_DATA = 128'h0,
   parameter [1:0]   BP_INIT   = 2'h0,
   parameter         LOCK_INIT = 1'b0,
   parameter         CYC_CNT   = `SFC_CYCLE_NS / `SFC_CYC_NS
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       chip_sel_n,
   input  wire       serial_clk,
   input  wire       serial_data_in,
   input  wire       write_protect_n,
   output reg        serial_data_out_ff,
   output reg        serial_data_out_oe_n_ff,
   output reg        op_start_ff,
   output reg  [7:0] op_code_ff,
   output reg  [1:0] op_bp_ff,
   output reg        write_enable_latch_ff,
   output reg        hardware_locked_mode_ff,
   output reg        cycle_busy_flag_ff
);
   localparam S_CMD = 2'h0;
   localparam S_OUT = 2'h1;
   localparam S_ARG = 2'h2;
   localparam S_IGN = 2'h3;
   // frame states: S_CMD collects the opcode, S_OUT streams bytes,
   // S_ARG collects the status write byte, S_IGN swallows the rest
   // of a frame that needs no further action
   // three-stage input samplers; stage one may be metastable,
   // so nothing but stages two and three is ever looked at
   reg [2:0] cs_s_ff;   // select pin history
   reg [2:0] ck_s_ff;   // link clock pin history
   reg [2:0] di_s_ff;   // link data pin history
   reg [2:0] wp_s_ff;   // protect pin history
   always @(posedge clk) begin
      if (!rst_n) begin
         cs_s_ff <= 3'h7;
         ck_s_ff <= 3'h0;
         di_s_ff <= 3'h0;
         wp_s_ff <= 3'h7;
      end else begin
         cs_s_ff <= {cs_s_ff[1:0], chip_sel_n};
         ck_s_ff <= {ck_s_ff[1:0], serial_clk};
         di_s_ff <= {di_s_ff[1:0], serial_data_in};
         wp_s_ff <= {wp_s_ff[1:0], write_protect_n};
      end
   end
   // stable levels: only stages two and three are looked at
   // a level moves only when both late stages agree
   reg cs_q_ff;
   reg ck_q_ff;
   reg wp_q_ff;
   always @(posedge clk) begin
      if (!rst_n) begin
         cs_q_ff <= 1'b1;
         ck_q_ff <= 1'b0;
         wp_q_ff <= 1'b1;
      end else begin
         if (cs_s_ff[1] == cs_s_ff[2]) cs_q_ff <= cs_s_ff[2];
         if (ck_s_ff[1] == ck_s_ff[2]) ck_q_ff <= ck_s_ff[2];
         if (wp_s_ff[1] == wp_s_ff[2]) wp_q_ff <= wp_s_ff[2];
      end
   end
   // edge strobes are one clk wide; look-ahead on the agreed level
   // saves a cycle of latency on every link edge
   wire ck_now  = (ck_s_ff[1] == ck_s_ff[2]) ? ck_s_ff[2] : ck_q_ff;
   wire cs_now  = (cs_s_ff[1] == cs_s_ff[2]) ? cs_s_ff[2] : cs_q_ff;
   wire sel     = !cs_now;
   wire rise    = sel && ck_now && !ck_q_ff;
   wire fall    = sel && !ck_now && ck_q_ff;
   wire desel   = cs_now && !cs_q_ff;
   // status image; bits 6..4 are tied low and the write byte's
   // low two bits never reach the register
   reg  [1:0] bp_ff;
   reg        lock_ff;
   wire       hw_lock = lock_ff && !wp_q_ff;
   wire [7:0] status  = {lock_ff, 3'h0, bp_ff, write_enable_latch_ff,
                         cycle_busy_flag_ff};
   // link shifter state; frame state, bit and id counters and output enable return
   // to idle on deselect; the opcode and status write byte stay, as deselect needs them
   reg  [1:0] st_ff;
   reg  [7:0] sh_ff;
   reg  [2:0] bitc_ff;
   reg  [7:0] cmd_ff;
   reg        inbyte_ff;      // a full byte just landed
   reg  [7:0] arg_ff;
   reg        argok_ff;
   reg  [4:0] idx_ff;
   reg  [7:0] obyte_ff;
   reg        ovalid_ff;
   reg        is_id_ff;
   reg [15:0] cyc_ff;
   // fifo carries queued output bytes; refilled per byte
   // status is pushed only into an empty fifo so a poll always
   // returns a fresh busy bit rather than a stale queued copy
   wire [7:0] f_out;
   wire       f_valid;
   wire       f_ready;
   reg        f_pop;
   reg  [7:0] f_in;
   reg        f_push;
   sfc_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (desel),
      .in_data   (f_in),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .out_data  (f_out),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );
   // byte source: id stream or repeating status
   // past the last id byte nothing is pushed and the line idles high
   always @* begin
      f_in   = status;
      f_push = 1'b0;
      if (st_ff == S_OUT && f_ready) begin
         if (!is_id_ff) begin
            f_push = !f_valid;
         end else if (idx_ff < `SFC_ID_BYTES) begin
            f_push = 1'b1;
            case (idx_ff)
               5'd0:    f_in = MAKER_ID;
               5'd1:    f_in = MEM_TYPE;
               5'd2:    f_in = MEM_CAP;
               5'd3:    f_in = `SFC_IDLEN;
               default: f_in = CUSTOM_DATA[8'd127 - {idx_ff - `SFC_CUST_FIRST, 3'h0} -: 8];
            endcase
         end
      end
   end
   // shift engine, msb first both ways
   // input bits are taken on link rises, output bits launched on falls,
   // so each bit settles before the host's next rise, half a link period less the sampler delay
   // the bit counter is shared by both directions of the frame
   always @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= S_CMD;
         sh_ff <= 8'h00;
         bitc_ff <= 3'h0;
         cmd_ff <= 8'h00;
         inbyte_ff <= 1'b0;
         arg_ff <= 8'h00;
         argok_ff <= 1'b0;
         idx_ff <= 5'd0;
         obyte_ff <= 8'h00;
         ovalid_ff <= 1'b0;
         is_id_ff <= 1'b0;
         f_pop <= 1'b0;
         serial_data_out_ff <= 1'b1;
         serial_data_out_oe_n_ff <= 1'b1;
      end else begin
         f_pop <= 1'b0;
         if (f_push && is_id_ff) idx_ff <= idx_ff + 5'd1;
         if (!sel) begin
            st_ff <= S_CMD;
            bitc_ff <= 3'h0;
            idx_ff <= 5'd0;
            ovalid_ff <= 1'b0;
            inbyte_ff <= 1'b0;                                      // clockless frame must not reuse it
            serial_data_out_oe_n_ff <= 1'b1;
         end else if (rise) begin
            sh_ff   <= {sh_ff[6:0], di_s_ff[2]};
            bitc_ff <= bitc_ff + 3'h1;
            inbyte_ff <= (bitc_ff == `SFC_BIT_LAST);
            // decode on the eighth rise; a read answer begins on the
            // very next fall, so the state must be set here
            if (bitc_ff == `SFC_BIT_LAST && st_ff == S_CMD) begin
               cmd_ff <= {sh_ff[6:0], di_s_ff[2]};
               case ({sh_ff[6:0], di_s_ff[2]})
                  `SFC_OP_RDSR: begin
                     st_ff <= S_OUT;
                     is_id_ff <= 1'b0;
                  end
                  `SFC_OP_RDID, `SFC_OP_RDID_ALT: begin
                     st_ff    <= cycle_busy_flag_ff ? S_IGN : S_OUT;
                     is_id_ff <= 1'b1;
                  end
                  `SFC_OP_WRSR: st_ff <= S_ARG;
                  default:      st_ff <= S_IGN;
               endcase
               argok_ff <= 1'b0;
            end else if (bitc_ff == `SFC_BIT_LAST && st_ff == S_ARG) begin
               arg_ff <= {sh_ff[6:0], di_s_ff[2]};
               argok_ff <= 1'b1;
               st_ff <= S_IGN;
            end
         // on a byte boundary the next byte is pulled; an empty fifo
         // shows ones rather than stalling the host
         end else if (fall && st_ff == S_OUT) begin
            serial_data_out_oe_n_ff <= 1'b0;
            if (!ovalid_ff || bitc_ff == 3'h0) begin
               serial_data_out_ff <= f_valid ? f_out[7] : 1'b1;
               obyte_ff  <= {f_out[6:0], 1'b1};
               ovalid_ff <= f_valid;
               f_pop     <= f_valid;
            end else begin
               serial_data_out_ff <= obyte_ff[7];
               obyte_ff <= {obyte_ff[6:0], 1'b1};
            end
         end
      end
   end
   // command completion on deselect at byte boundary
   // all writes act only on deselect, so a cut frame changes nothing
   wire on_byte = desel && bitc_ff == 3'h0 && inbyte_ff;
   wire do_wren = on_byte && cmd_ff == `SFC_OP_WREN && !cycle_busy_flag_ff;
   wire do_wrdi = on_byte && cmd_ff == `SFC_OP_WRDI && !cycle_busy_flag_ff;
   wire do_wrsr = on_byte && cmd_ff == `SFC_OP_WRSR && argok_ff && write_enable_latch_ff
                  && !hw_lock && !cycle_busy_flag_ff;
   wire do_pe   = on_byte && write_enable_latch_ff && !cycle_busy_flag_ff
                  && ((cmd_ff == `SFC_OP_PP) || (cmd_ff == `SFC_OP_SE)
                  || (cmd_ff == `SFC_OP_BE && bp_ff == 2'h0));
   // latch, protect bits, busy timer and outward handoff
   // the busy time is a fixed count; the array engine's real timing
   // is not fed back, a trade for a self-contained slice
   always @(posedge clk) begin
      if (!rst_n) begin
         write_enable_latch_ff <= 1'b0;
         bp_ff <= BP_INIT;
         lock_ff <= LOCK_INIT;
         cycle_busy_flag_ff <= 1'b0;
         cyc_ff <= 16'h0000;
         op_start_ff <= 1'b0;
         op_code_ff <= 8'h00;
         op_bp_ff <= 2'h0;
         hardware_locked_mode_ff <= 1'b0;
      end else begin
         hardware_locked_mode_ff <= hw_lock;
         op_start_ff <= 1'b0;
         if (do_wren) write_enable_latch_ff <= 1'b1;
         if (do_wrdi) write_enable_latch_ff <= 1'b0;
         if (do_wrsr || do_pe) begin
            cycle_busy_flag_ff <= 1'b1;
            cyc_ff      <= CYC_CNT[15:0];
            op_start_ff <= do_pe;
            op_code_ff  <= cmd_ff;
            op_bp_ff    <= bp_ff;
            if (do_wrsr) begin
               bp_ff   <= {arg_ff[`SFC_ST_PROT1], arg_ff[`SFC_ST_PROT0]};
               lock_ff <= arg_ff[`SFC_ST_LOCK];
            end
         // count down; the latch drops in the same cycle busy ends
         // so a poll never sees idle with the latch still set
         end else if (cycle_busy_flag_ff) begin
            if (cyc_ff <= 16'h0001) begin
               cycle_busy_flag_ff    <= 1'b0;
               write_enable_latch_ff <= 1'b0;
            end
            cyc_ff <= cyc_ff - 16'h0001;
         end
      end
   end
endmodule // sfc_top
`default_nettype wire

// File: verif/sfc_sva.sv
// Purpose: port assertions for the flash command slice
// Assumes: bound to sfc_top, one clock domain
// Notes:   bytes on the wire are judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"
module sfc_sva (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       chip_sel_n,
   input wire logic       serial_clk,
   input wire logic       serial_data_in,
   input wire logic       write_protect_n,
   input wire logic       serial_data_out_ff,
   input wire logic       serial_data_out_oe_n_ff,
   input wire logic       op_start_ff,
   input wire logic [7:0] op_code_ff,
   input wire logic [1:0] op_bp_ff,
   input wire logic       write_enable_latch_ff,
   input wire logic       hardware_locked_mode_ff,
   input wire logic       cycle_busy_flag_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // output parks once deselect has passed the samplers
   oe_idle_a: assert property (chip_sel_n [*6] |-> serial_data_out_oe_n_ff) else $error("data out driven");
   unlock_pin_a: assert property (write_protect_n [*6] |-> !hardware_locked_mode_ff) else $error("lock stuck");
   start_wel_a: assert property (op_start_ff |-> write_enable_latch_ff) else $error("start without latch");
   start_idle_a: assert property (op_start_ff |-> !$past(cycle_busy_flag_ff)) else $error("start while busy");
   busy_follow_a: assert property (op_start_ff |-> ##[0:2] cycle_busy_flag_ff) else $error("no busy");
   bulk_bp_a: assert property (op_start_ff && op_code_ff == `SFC_OP_BE |-> op_bp_ff == 2'h0)
      else $error("bulk erase protected");
   busy_hold_a: assert property ($rose(cycle_busy_flag_ff) |-> cycle_busy_flag_ff [*8]) else $error("busy short");
   busy_end_wel_a: assert property ($fell(cycle_busy_flag_ff) |-> ##[0:1] !write_enable_latch_ff)
      else $error("latch kept");
endmodule // sfc_sva
`default_nettype wire

// File: verif/sfc_host.sv
// Purpose: behavioural spi host for the link pins
// Assumes: mode 0, clock parked low between frames
// Notes:   a released data line reads back inverted
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
   input  wire logic clk,
   input  wire logic data_out,
   input  wire logic data_oe_n,
   output var  logic chip_sel_n,
   output var  logic serial_clk,
   output var  logic serial_data_in
);
   logic last_bit;
   wire  logic line_level = data_oe_n ? ~last_bit : data_out;
   // idle pins
   initial begin
      chip_sel_n = 1'b1;
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
      last_bit = 1'b0;
   end
   // no pull on the line: remember the last driven bit
   always @(posedge clk) begin
      if (!data_oe_n)
         last_bit <= data_out;
   end
   // one frame; never carries a power-down opcode
   task automatic xfer(input logic [191:0] tx, input int nbits, output logic [191:0] rx, output logic drove);
      rx = 192'h0;
      drove = 1'b0;
      chip_sel_n <= 1'b0;
      #200;
      for (int i = 0; i < nbits; i++) begin
         serial_data_in <= tx[191-i];
         #62.5 serial_clk <= 1'b1;
         rx = {rx[190:0], line_level};
         drove = drove | ~data_oe_n;
         #62.5 serial_clk <= 1'b0;
      end
      #100 chip_sel_n <= 1'b1;
      #400;
   endtask
endmodule // sfc_host
`default_nettype wire

// File: verif/spi_flash_status_id_wel_tb.sv
// Purpose: self-checking bench for the flash command slice
// Assumes: internal cycle lengthened to 3000 clocks
// Notes:   one random status byte among fixed corner cases
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_id_wel_tb;
   localparam int CYC = 3000;
   localparam logic [159:0] ID = {8'h6b, 8'h47, 8'h33, 8'h10, 128'h0123456789abcdeffedcba9876543210}; // arbitrary ids
   logic       clk, rst_n, wp_n, drove;
   logic [191:0] rx;
   logic [7:0] sb;
   logic [7:0] ids [2] = '{8'h9f, 8'h9e};
   wire  logic cs_n, sck, mosi, dout, oe_n, start, wel, lkm, busy;
   wire  logic [7:0] opc;
   wire  logic [1:0] obp;
   int         miscompares, checks_done, cycles;
   sfc_top #(.MAKER_ID(ID[159:152]), .MEM_TYPE(ID[151:144]), .MEM_CAP(ID[143:136]), .CUSTOM_DATA(ID[127:0]),
      .CYC_CNT(CYC)) DUT (.clk(clk), .rst_n(rst_n), .chip_sel_n(cs_n), .serial_clk(sck), .serial_data_in(mosi),
      .write_protect_n(wp_n), .serial_data_out_ff(dout), .serial_data_out_oe_n_ff(oe_n), .op_start_ff(start),
      .op_code_ff(opc), .op_bp_ff(obp), .write_enable_latch_ff(wel), .hardware_locked_mode_ff(lkm),
      .cycle_busy_flag_ff(busy));
   sfc_host host (.clk(clk), .data_out(dout), .data_oe_n(oe_n), .chip_sel_n(cs_n), .serial_clk(sck),
      .serial_data_in(mosi));
   // expected status byte
   function automatic logic [7:0] st(input logic b, w, input logic [1:0] bp, input logic lk);
      return {lk, 3'h0, bp, w, b};
   endfunction
   task automatic check(input logic [159:0] seen, input logic [159:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic [7:0] code, input logic [7:0] arg, input int nbits);
      host.xfer({code, arg, 176'h0}, nbits, rx, drove);
   endtask
   // two bytes prove the status byte repeats
   task automatic rd_status(input logic [7:0] exp);
      op(8'h05, 8'h00, 24);
      check(160'(rx[15:0]), 160'({exp, exp}));
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard, well above the expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      cycles = 0;
      void'($urandom(32'hd72faaea));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      check(160'({oe_n, wel, lkm, busy}), 160'(4'h8));
      rd_status(st(0, 0, 0, 0));
      $display("test reset done");
      op(8'h06, 8'h00, 8);
      rd_status(st(0, 1, 0, 0));
      op(8'h04, 8'h00, 9);
      check(160'(wel), 160'(1));
      op(8'h04, 8'h00, 8);
      check(160'(wel), 160'(0));
      $display("test latch done");
      foreach (ids[k]) begin
         host.xfer({ids[k], 184'h0}, 168, rx, drove);
         check(rx[159:0], ID);
      end
      op(8'h9f, 8'h00, 20);
      check(160'(rx[11:0]), 160'(ID[159:148]));
      rd_status(st(0, 0, 0, 0));
      $display("test id done");
      sb = 8'($urandom);
      op(8'h06, 8'h00, 8);
      op(8'h01, sb, 16);
      rd_status(st(1, 1, sb[3:2], sb[7]));
      repeat (CYC) @(posedge clk);
      rd_status(st(0, 0, sb[3:2], sb[7]));
      op(8'h01, ~sb, 16);
      rd_status(st(0, 0, sb[3:2], sb[7]));
      $display("test status write done");
      op(8'h06, 8'h00, 8);
      op(8'h01, 8'h84, 16);
      repeat (CYC) @(posedge clk);
      wp_n <= 1'b0;
      repeat (8) @(posedge clk);
      check(160'(lkm), 160'(1));
      op(8'h06, 8'h00, 8);
      op(8'h01, 8'h08, 16);
      op(8'hc7, 8'h00, 8);
      rd_status(st(0, 1, 2'h1, 1));
      wp_n <= 1'b1;
      op(8'h01, 8'h00, 16);
      repeat (CYC) @(posedge clk);
      check(160'(lkm), 160'(0));
      $display("test lock done");
      op(8'h06, 8'h00, 8);
      op(8'hc7, 8'h00, 8);
      op(8'h9f, 8'h00, 24);
      check(160'({drove, busy}), 160'(1));
      check(160'({opc, obp}), 160'({8'hc7, 2'h0}));
      rd_status(st(1, 1, 0, 0));
      repeat (CYC) @(posedge clk);
      rd_status(st(0, 0, 0, 0));
      $display("test erase done");
      report_and_stop();
   end
endmodule // spi_flash_status_id_wel_tb
bind sfc_top sfc_sva chk (.clk(clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
   .serial_data_in(serial_data_in), .write_protect_n(write_protect_n), .serial_data_out_ff(serial_data_out_ff),
   .serial_data_out_oe_n_ff(serial_data_out_oe_n_ff), .op_start_ff(op_start_ff), .op_code_ff(op_code_ff),
   .op_bp_ff(op_bp_ff), .write_enable_latch_ff(write_enable_latch_ff),
   .hardware_locked_mode_ff(hardware_locked_mode_ff), .cycle_busy_flag_ff(cycle_busy_flag_ff));
`default_nettype wire
